// *** kp_defines.svh ***
/*
  Constants of the keypad event buffer: command codes, register offsets,
  interrupt bit positions, reset values and timing figures.
  Assumes a 50 MHz core clock and the include guard below.
*/
// Notes on behaviour
// RULE1: Auto-send forwards each key code at once.
// RULE2: Buffered mode keeps up to ten codes.
// RULE3: Poll returns one code, MSB flags more.
// RULE4: Poll on empty buffer returns zero.
// RULE5: Host turns auto-send off before polling.
// RULE6: Clear command empties the whole buffer.
// RULE7: Settle time is parameter times 6.554 ms.
// RULE8: Typematic: code now, after 1 s, 5/s.
// RULE9: Hold: down code on press, up on release.
// RULE10: Mode byte 1 hold, 0 typematic.
// RULE11: Separate command turns auto-repeat off.
// RULE12: Assign 25 down, 25 up; 255 keeps.
// RULE13: Default down codes are 65 to 89.
// RULE14: Default up codes are 97 to 121.
// RULE15: Every command starts with prefix 0xFE.
// RULE16: Full buffer drops new codes.
// RULE17: Unknown command code is ignored.
`ifndef KP_DEFINES_SVH
`define KP_DEFINES_SVH

// ==========================================
// Keypad geometry and buffer depth
`define KP_NKEYS 25
`define KP_BUF_DEPTH 4'hA
`define KP_LAST_PARAM 6'h31

// ==========================================
// Command bytes
`define KP_PREFIX 8'hFE
`define KP_OP_AUTO_ON 8'h41
`define KP_OP_AUTO_OFF 8'h4F
`define KP_OP_POLL 8'h26
`define KP_OP_CLEAR 8'h45
`define KP_OP_DEBOUNCE 8'h55
`define KP_OP_RPT_MODE 8'h7E
`define KP_OP_RPT_OFF 8'h60
`define KP_OP_ASSIGN 8'hD5
`define KP_CODE_KEEP 8'hFF
`define KP_MODE_HOLD 8'h01

// ==========================================
// Reset values
`define KP_DN_BASE 8'h41
`define KP_UP_BASE 8'h61
`define KP_DEB_DEFAULT 8'h08

// ==========================================
// Register byte offsets and interrupt bits
`define KP_REG_CMD 8'h00
`define KP_REG_STATUS 8'h04
`define KP_REG_INT_STAT 8'h08
`define KP_REG_INT_MASK 8'h0C
`define KP_INT_KEY 0
`define KP_INT_DROP 1

// ==========================================
// Timing
`define KP_CLK_MHZ 50
`define KP_TICK_US 6554
`define KP_RPT_DELAY_US 1000000
`define KP_RPT_RATE_US 200000

`endif

// *** kp_pkg.sv ***
/*
  Types of the keypad event buffer: parser states, the host byte
  carrier and the state records of both modules.
  Assumes kp_defines.svh is on the include path.
*/
`include "kp_defines.svh"

package kp_pkg;

  // ==========================================
  // Command parser states
  typedef enum logic [2:0] {
    PS_IDLE,
    PS_CMD,
    PS_DEB,
    PS_MODE,
    PS_CODES
  } kp_pstate_t;

  // One byte toward the host, valid for one cycle
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } kp_byte_t;

  // Debouncer state
  typedef struct packed {
    logic [`KP_NKEYS-1:0] s1;
    logic [`KP_NKEYS-1:0] s2;
    logic [`KP_NKEYS-1:0] stable;
    logic [`KP_NKEYS-1:0][7:0] cnt;
  } kp_db_st_t;

  // Event block state
  typedef struct packed {
    kp_pstate_t ps;
    logic [5:0] pidx;
    logic auto_tx;
    logic hold;
    logic rpt_en;
    logic [7:0] deb;
    logic [`KP_NKEYS-1:0][7:0] dn;
    logic [`KP_NKEYS-1:0][7:0] up;
    logic [9:0][7:0] kbuf;
    logic [3:0] head;
    logic [3:0] cnt;
    logic [`KP_NKEYS-1:0] prev;
    logic [`KP_NKEYS-1:0] pend_dn;
    logic [`KP_NKEYS-1:0] pend_up;
    logic rep_act;
    logic [4:0] rep_key;
    logic rep_pend;
    logic [25:0] rep_cnt;
    logic [18:0] tick_cnt;
    logic tick;
    logic a_valid;
    logic a_write;
    logic [7:0] a_addr;
    logic [31:0] rdata;
    logic rdy;
    kp_byte_t out;
    logic [1:0] int_stat;
    logic [1:0] int_mask;
    logic irq;
  } kp_top_st_t;

endpackage

// *** kp_debounce.sv ***
/*
  Two-flop synchronisers and per-key settle counters for the keypad.
  Assumes a tick pulse from the event block every debounce increment.
*/
`include "kp_defines.svh"

module kp_debounce (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Settings
  input wire logic [7:0] deb,
  input wire logic tick,
  // Keys
  input wire logic [`KP_NKEYS-1:0] key_raw,
  output logic [`KP_NKEYS-1:0] stable
);
  import kp_pkg::*;

  kp_db_st_t q; // Registered state
  kp_db_st_t s; // Next state

  // ==========================================
  // Next state
  always_comb begin
    s = q;
    // First flop feeds only the second
    s.s1 = key_raw;
    s.s2 = q.s1;
    for (int i = 0; i < `KP_NKEYS; i++) begin
      if (q.s2[i] == q.stable[i]) begin
        // No change pending
        s.cnt[i] = 8'h00;
      // RULE7: settle then accept
      end else if (q.cnt[i] >= deb) begin
        s.stable[i] = q.s2[i];
        s.cnt[i] = 8'h00;
      end else if (tick) begin
        s.cnt[i] = q.cnt[i] + 8'h01;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= s;
    end
  end

  assign stable = q.stable;

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_settle;
    !$stable(q.stable[0]) |-> $past(q.cnt[0]) >= $past(deb);
  endproperty
  a_settle: assert property (p_settle) // RULE7
    else $error("key accepted before settle count");

endmodule

// *** kp_event.sv ***
/*
  Keypad event buffer: parses 0xFE-prefixed keypad commands written over
  AHB-Lite, turns debounced key edges into down and up codes, repeats
  down codes, and sends codes at once or holds them for polling.
  Assumes one 50 MHz clock, a synchronous reset and raw key pins.
*/
`include "kp_defines.svh"

module kp_event #(
  parameter int TICK_CYC = `KP_TICK_US * `KP_CLK_MHZ,
  parameter int RPT_DELAY_CYC = `KP_RPT_DELAY_US * `KP_CLK_MHZ,
  parameter int RPT_RATE_CYC = `KP_RPT_RATE_US * `KP_CLK_MHZ
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Keypad pins
  input wire logic [`KP_NKEYS-1:0] key_raw,
  // Bytes to the host
  output kp_pkg::kp_byte_t host_out,
  // Interrupt
  output logic irq
);
  import kp_pkg::*;

  kp_top_st_t q; // Registered state
  kp_top_st_t s; // Next state
  logic [`KP_NKEYS-1:0] st; // Debounced keys
  logic [`KP_NKEYS-1:0] rise; // Press edges
  logic [`KP_NKEYS-1:0] fall; // Release edges
  logic cmd_wr; // Byte written to command register
  logic [7:0] b; // That byte
  logic poll_c; // Poll command taken
  logic clear_c; // Clear command taken
  logic hit_dn; // A down event pending
  logic hit_up; // An up event pending
  logic [4:0] k; // Key of pending down
  logic [4:0] ku; // Key of pending up
  logic ev; // A code is produced
  logic [7:0] ev_code; // The code
  logic [4:0] tail5; // Write slot before wrap
  logic [3:0] tail; // Write slot
  logic [3:0] nhead; // Read slot after a poll
  logic [1:0] int_set; // Events this cycle

  // Reset image, defaults restored here
  function automatic kp_top_st_t kp_rst();
    kp_top_st_t r;
    r = '0;
    r.ps = PS_IDLE;
    r.auto_tx = 1'b1;
    r.rpt_en = 1'b1;
    r.deb = `KP_DEB_DEFAULT;
    r.rdy = 1'b1;
    for (int i = 0; i < `KP_NKEYS; i++) begin
      // RULE13: down codes 65 up
      r.dn[i] = `KP_DN_BASE + 8'(i);
      // RULE14: up codes 97 up
      r.up[i] = `KP_UP_BASE + 8'(i);
    end
    return r;
  endfunction

  // ==========================================
  // Debouncer
  kp_debounce u_deb (
    .core_clk(core_clk),
    .reset(reset),
    .deb(q.deb),
    .tick(q.tick),
    .key_raw(key_raw),
    .stable(st)
  );

  // ==========================================
  // Next state
  always_comb begin
    s = q;
    s.out = '0;
    s.tick = 1'b0;
    poll_c = 1'b0;
    clear_c = 1'b0;
    hit_dn = 1'b0;
    hit_up = 1'b0;
    k = 5'h00;
    ku = 5'h00;
    ev = 1'b0;
    ev_code = 8'h00;
    int_set = 2'h0;
    b = hwdata[7:0];
    cmd_wr = q.a_valid && q.a_write && (q.a_addr == `KP_REG_CMD);

    // Debounce increment prescaler
    if (q.tick_cnt == 19'(TICK_CYC - 1)) begin
      s.tick_cnt = 19'h00000;
      s.tick = 1'b1;
    end else begin
      s.tick_cnt = q.tick_cnt + 19'h00001;
    end

    // Command parser, one byte per write
    unique case (q.ps)
      PS_IDLE: begin
        // RULE15: wait for prefix
        if (cmd_wr && b == `KP_PREFIX) begin
          s.ps = PS_CMD;
        end
      end
      PS_CMD: begin
        if (cmd_wr) begin
          s.ps = PS_IDLE;
          case (b)
            // RULE1: auto-send on
            `KP_OP_AUTO_ON: s.auto_tx = 1'b1;
            // RULE2: buffered mode
            `KP_OP_AUTO_OFF: s.auto_tx = 1'b0;
            `KP_OP_POLL: poll_c = 1'b1;
            `KP_OP_CLEAR: clear_c = 1'b1;
            `KP_OP_DEBOUNCE: s.ps = PS_DEB;
            `KP_OP_RPT_MODE: s.ps = PS_MODE;
            // RULE11: repeat off
            `KP_OP_RPT_OFF: s.rpt_en = 1'b0;
            `KP_OP_ASSIGN: begin
              s.ps = PS_CODES;
              s.pidx = 6'h00;
            end
            // RULE17: unknown code ignored
            default: s.ps = PS_IDLE;
          endcase
        end
      end
      PS_DEB: begin
        // RULE7: new settle count
        if (cmd_wr) begin
          s.deb = b;
          s.ps = PS_IDLE;
        end
      end
      PS_MODE: begin
        // RULE10: 1 hold, 0 typematic
        if (cmd_wr) begin
          s.hold = (b == `KP_MODE_HOLD);
          s.rpt_en = 1'b1;
          s.ps = PS_IDLE;
        end
      end
      PS_CODES: begin
        if (cmd_wr) begin
          // RULE12: 255 keeps the code
          if (b != `KP_CODE_KEEP) begin
            if (q.pidx < 6'(`KP_NKEYS)) begin
              s.dn[q.pidx[4:0]] = b;
            end else begin
              s.up[5'(q.pidx - 6'(`KP_NKEYS))] = b;
            end
          end
          if (q.pidx == `KP_LAST_PARAM) begin
            s.ps = PS_IDLE;
          end else begin
            s.pidx = q.pidx + 6'h01;
          end
        end
      end
    endcase

    // Key edges
    rise = st & ~q.prev;
    fall = ~st & q.prev;
    s.prev = st;

    // Lowest pending key wins
    for (int i = `KP_NKEYS - 1; i >= 0; i--) begin
      if (q.pend_dn[i]) begin
        hit_dn = 1'b1;
        k = 5'(i);
      end
      if (q.pend_up[i]) begin
        hit_up = 1'b1;
        ku = 5'(i);
      end
    end

    // Pick one code when no poll or clear owns the cycle
    if (!poll_c && !clear_c) begin
      if (q.rep_pend) begin
        // RULE8: repeat of held key
        ev = 1'b1;
        ev_code = q.dn[q.rep_key];
        s.rep_pend = 1'b0;
      end else if (hit_dn) begin
        ev = 1'b1;
        ev_code = q.dn[k];
        s.pend_dn[k] = 1'b0;
        // RULE8: first repeat after delay
        if (q.rpt_en && !q.hold) begin
          s.rep_act = 1'b1;
          s.rep_key = k;
          s.rep_cnt = 26'(RPT_DELAY_CYC - 1);
        end
      end else if (hit_up) begin
        // RULE9: up code on release
        ev = 1'b1;
        ev_code = q.up[ku];
        s.pend_up[ku] = 1'b0;
      end
    end

    // New edges queue behind the one just taken
    s.pend_dn = s.pend_dn | rise;
    // RULE9: release only reported in hold mode
    if (q.rpt_en && q.hold) begin
      s.pend_up = s.pend_up | fall;
    end

    // Repeat timer, stopped by release or mode change
    if (!(q.rpt_en && !q.hold) || (q.rep_act && fall[q.rep_key])) begin
      s.rep_act = 1'b0;
      s.rep_pend = 1'b0;
    end else if (q.rep_act && !(ev && hit_dn && !q.rep_pend)) begin
      // RULE8: five per second
      if (q.rep_cnt == 26'h0000000) begin
        s.rep_pend = 1'b1;
        s.rep_cnt = 26'(RPT_RATE_CYC - 1);
      end else begin
        s.rep_cnt = q.rep_cnt - 26'h0000001;
      end
    end

    // Ring slots
    tail5 = {1'b0, q.head} + {1'b0, q.cnt};
    if (tail5 >= {1'b0, `KP_BUF_DEPTH}) begin
      tail = 4'(tail5 - {1'b0, `KP_BUF_DEPTH});
    end else begin
      tail = tail5[3:0];
    end
    nhead = (q.head == `KP_BUF_DEPTH - 4'h1) ? 4'h0 : q.head + 4'h1;

    // Deliver or store the produced code
    if (ev) begin
      int_set[`KP_INT_KEY] = 1'b1;
      if (q.auto_tx) begin
        // RULE1: send at once
        s.out.valid = 1'b1;
        s.out.data = ev_code;
      end else if (q.cnt < `KP_BUF_DEPTH) begin
        // RULE2: hold for polling
        s.kbuf[tail] = ev_code;
        s.cnt = q.cnt + 4'h1;
      end else begin
        // RULE16: full, drop newest
        int_set[`KP_INT_DROP] = 1'b1;
      end
    end

    // Poll answer
    if (poll_c) begin
      s.out.valid = 1'b1;
      if (q.cnt == 4'h0) begin
        // RULE4: empty gives zero
        s.out.data = 8'h00;
      end else begin
        // RULE3: MSB says more remain
        s.out.data = {(q.cnt > 4'h1), q.kbuf[q.head][6:0]};
        s.head = nhead;
        s.cnt = q.cnt - 4'h1;
      end
    end

    // RULE6: drop every stored code
    if (clear_c) begin
      s.cnt = 4'h0;
      s.head = 4'h0;
    end

    // Register writes in the data phase; set wins over clear
    s.int_stat = q.int_stat | int_set;
    if (q.a_valid && q.a_write) begin
      if (q.a_addr == `KP_REG_INT_STAT) begin
        s.int_stat = (q.int_stat & ~hwdata[1:0]) | int_set;
      end
      if (q.a_addr == `KP_REG_INT_MASK) begin
        s.int_mask = hwdata[1:0];
      end
    end
    s.irq = |(s.int_stat & s.int_mask);

    // Address phase capture and read data
    s.a_valid = hsel && htrans[1] && hready;
    s.a_write = hwrite;
    s.a_addr = haddr[7:0];
    s.rdata = 32'h00000000;
    if (hsel && htrans[1] && hready && !hwrite) begin
      case (haddr[7:0])
        `KP_REG_STATUS: s.rdata = {16'h0000, q.deb, q.cnt,
          (q.ps != PS_IDLE), q.rpt_en, q.hold, q.auto_tx};
        `KP_REG_INT_STAT: s.rdata = {30'h00000000, q.int_stat};
        `KP_REG_INT_MASK: s.rdata = {30'h00000000, q.int_mask};
        // Command and unmapped words read zero
        default: s.rdata = 32'h00000000;
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      q <= kp_rst();
    end else begin
      q <= s;
    end
  end

  // ==========================================
  // Outputs
  assign hrdata = q.rdata;
  assign hreadyout = q.rdy;
  assign hresp = 1'b0;
  assign host_out = q.out;
  assign irq = q.irq;

  // ==========================================
  // Checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_auto_fwd;
    ev && q.auto_tx |=> host_out.valid && host_out.data == $past(ev_code);
  endproperty
  a_auto_fwd: assert property (p_auto_fwd) // RULE1
    else $error("code not forwarded in auto mode");

  property p_buf_store;
    ev && !q.auto_tx && q.cnt < 4'hA |=> q.cnt == $past(q.cnt) + 4'h1
      && !host_out.valid;
  endproperty
  a_buf_store: assert property (p_buf_store) // RULE2
    else $error("code not stored in buffered mode");

  property p_poll_more;
    poll_c && q.cnt > 4'h1 |=> host_out.valid && host_out.data[7]
      ##1 !host_out.valid;
  endproperty
  a_poll_more: assert property (p_poll_more) // RULE3
    else $error("poll lost the more flag");

  property p_poll_empty;
    poll_c && q.cnt == 4'h0 |=> host_out.valid && host_out.data == 8'h00;
  endproperty
  a_poll_empty: assert property (p_poll_empty) // RULE4
    else $error("empty poll did not return zero");

  property p_clear;
    clear_c |=> q.cnt == 4'h0;
  endproperty
  a_clear: assert property (p_clear) // RULE6
    else $error("clear left codes");

  property p_rate;
    $rose(q.rep_pend) |-> $past(q.rep_cnt) == 26'h0000000
      && q.rep_cnt == 26'(RPT_RATE_CYC - 1);
  endproperty
  a_rate: assert property (p_rate) // RULE8
    else $error("repeat fired off schedule");

  property p_keep;
    q.ps == PS_CODES && cmd_wr && b == 8'hFF |=> q.dn == $past(q.dn)
      && q.up == $past(q.up);
  endproperty
  a_keep: assert property (p_keep) // RULE12
    else $error("keep value changed a code");

  property p_defaults;
    $fell(reset) |-> q.dn[0] == 8'h41 && q.dn[24] == 8'h59
      && q.up[0] == 8'h61 && q.up[24] == 8'h79 && q.auto_tx && !q.hold;
  endproperty
  a_defaults: assert property (p_defaults) // RULE13
    else $error("defaults not restored");

  property p_full_drop;
    ev && !q.auto_tx && q.cnt == 4'hA |=> q.cnt == 4'hA
      && q.int_stat[1];
  endproperty
  a_full_drop: assert property (p_full_drop) // RULE16
    else $error("full buffer accepted a code");

  property p_unknown;
    q.ps == PS_CMD && cmd_wr && b == 8'h00 |=> q.ps == PS_IDLE
      && $stable(q.auto_tx) && $stable(q.cnt) && !host_out.valid;
  endproperty
  a_unknown: assert property (p_unknown) // RULE17
    else $error("unknown code changed state");

endmodule

// *** kp_host_rx.sv ***
/*
  Host side receiver: collects every byte the keypad block sends.
  Assumes one clock and the byte carrier of kp_pkg.
*/
module kp_host_rx
  import kp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Bytes from the block
  input wire kp_pkg::kp_byte_t host_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$]; // Bytes seen, oldest first
  // ==========================================
  // Capture
  // Take a byte on each one-cycle valid pulse
  always @(posedge core_clk) begin
    if (!reset && host_out.valid === 1'b1) begin
      got.push_back(host_out.data);
    end
  end
endmodule

// *** keypad_event_buffer_tb.sv ***
/*
  Testbench of the keypad event block: AHB-Lite master, key stimulus
  and a queue model of codes and buffer.
  Assumes kp_event and kp_host_rx, one 50 MHz clock.
*/
module keypad_event_buffer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import kp_pkg::*;
  // ==========================================
  // Signals
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic hsel = 1'b0; // Slave select, raised with each address phase
  logic [2:0] hsize = 3'h0; // Transfer size, word during address phase
  logic [24:0] key_raw = 25'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  kp_byte_t host_out;
  int mismatches = 0;
  int checks_done = 0;
  int dn[25]; // Model down codes
  int up[25]; // Model up codes
  int expq[$]; // Bytes expected at the host
  int bq[$]; // Model key buffer
  bit auto_m = 1'b1;
  bit hold_m = 1'b0;
  bit rpt_m = 1'b1;

  // 50 MHz clock
  always #10 core_clk = ~core_clk;

  kp_event #(.TICK_CYC(4), .RPT_DELAY_CYC(200), .RPT_RATE_CYC(40)) i_dut (
    .core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .key_raw(key_raw), .host_out(host_out), .irq(irq));

  kp_host_rx i_host (.core_clk(core_clk), .reset(reset),
    .host_out(host_out));

  // ==========================================
  // Checking and closing
  task automatic check(string what, logic [31:0] seen, logic [31:0] e);
    checks_done++;
    if (seen !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, e, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================
  // Bus cycles
  // One single transfer; entered right after a rising edge
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    logic r;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= 3'h2;
    do begin
      @(negedge core_clk);
      r = hreadyout;
      @(posedge core_clk);
    end while (r !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(negedge core_clk);
      r = hreadyout;
      rd = hrdata;
      @(posedge core_clk);
    end while (r !== 1'b1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input string s);
    logic [31:0] d;
    ahb(1'b0, a, 32'h0, d);
    check(s, d, e);
  endtask

  task automatic cmd(input logic [7:0] c);
    wr(8'h00, 32'h0000_00FE);
    wr(8'h00, {24'h0, c});
  endtask

  task automatic irq_chk(input logic e, input string s);
    repeat (2) @(negedge core_clk);
    check(s, irq, e);
    @(posedge core_clk);
  endtask

  // ==========================================
  // Keys and model
  task automatic emit(input int c);
    if (auto_m) begin
      expq.push_back(c);
    end else if (bq.size() < 10) begin
      bq.push_back(c);
    end
  endtask

  task automatic press(input int k, input int hold_cyc);
    int n0;
    n0 = i_host.got.size();
    key_raw[k] <= 1'b1;
    emit(dn[k]);
    repeat (28) @(posedge core_clk);
    check("settle", i_host.got.size(), n0);
    repeat (hold_cyc - 28) @(posedge core_clk);
    key_raw[k] <= 1'b0;
    // Hold mode with repeat on answers a release with the up code
    if (hold_m && rpt_m) begin
      emit(up[k]);
    end
    repeat (60) @(posedge core_clk);
  endtask

  task automatic poll();
    int e;
    cmd(8'h26);
    e = bq.size() == 0 ? 0 : ((bq.size() > 1) << 7) | (bq[0] & 8'h7F);
    if (bq.size() > 0) begin
      bq.delete(0);
    end
    repeat (3) @(posedge core_clk);
    expq.push_back(e);
  endtask

  task automatic drain(input string s);
    check(s, i_host.got.size(), expq.size());
    while (expq.size() > 0 && i_host.got.size() > 0) begin
      check(s, i_host.got.pop_front(), expq.pop_front());
    end
    expq.delete();
    i_host.got.delete();
  endtask

  // ==========================================
  // Watchdog
  initial begin
    repeat (40000) @(posedge core_clk);
    mismatches++;
    end_sim();
  end

  // ==========================================
  // Main sequence
  initial begin
    logic [31:0] rnd;
    logic [31:0] d;
    logic [7:0] c;
    for (int k = 0; k < 25; k++) begin
      dn[k] = 8'h41 + k;
      up[k] = 8'h61 + k;
    end
    rnd = $urandom(32'h520AC087);
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rchk(8'h04, 32'h0000_0805, "status reset");
    rchk(8'h40, 32'h0, "unmapped");
    check("hresp", hresp, 1'b0);
    // Typematic: code, then repeats after the delay
    expq = '{8'h41, 8'h41, 8'h41};
    press(0, 300);
    drain("typematic");
    cmd(8'h00);
    rchk(8'h04, 32'h0000_0805, "unknown");
    cmd(8'h7E);
    wr(8'h00, 32'h1);
    hold_m = 1'b1;
    rchk(8'h04, 32'h0000_0807, "hold mode");
    for (int k = 0; k < 25; k++) press(k, 60);
    drain("defaults");
    // Random codes, some kept with 255
    cmd(8'hD5);
    for (int i = 0; i < 50; i++) begin
      rnd = $urandom;
      c = (rnd[1:0] == 2'h0) ? 8'hFF : {1'b0, rnd[8:2]};
      wr(8'h00, {24'h0, c});
      if (c != 8'hFF && i < 25) dn[i] = c;
      if (c != 8'hFF && i >= 25) up[i - 25] = c;
    end
    for (int k = 0; k < 25; k++) press(k, 60);
    drain("assigned");
    cmd(8'h4F);
    auto_m = 1'b0;
    cmd(8'h60);
    rpt_m = 1'b0;
    wr(8'h08, 32'h3);
    for (int k = 0; k < 12; k++) press(k, 60);
    drain("buffered");
    ahb(1'b0, 8'h04, 32'h0, d);
    check("count", d[7:4], 4'hA);
    rchk(8'h08, 32'h3, "int status");
    irq_chk(1'b0, "irq masked");
    wr(8'h0C, 32'h2);
    rchk(8'h0C, 32'h2, "int mask");
    irq_chk(1'b1, "irq raised");
    wr(8'h08, 32'h3);
    irq_chk(1'b0, "irq cleared");
    rchk(8'h08, 32'h0, "int cleared");
    repeat (11) poll();
    drain("polls");
    press(3, 60);
    press(4, 60);
    cmd(8'h45);
    bq.delete();
    poll();
    drain("cleared");
    cmd(8'h41);
    auto_m = 1'b1;
    press(2, 300);
    drain("no repeat");
    cmd(8'h7E);
    wr(8'h00, 32'h0);
    hold_m = 1'b0;
    rpt_m = 1'b1;
    rchk(8'h04, 32'h0000_0805, "typematic");
    // Longer settle count: no code while the default count would pass
    cmd(8'h55);
    wr(8'h00, 32'h0C);
    rchk(8'h04, 32'h0000_0C05, "debounce");
    key_raw[1] <= 1'b1;
    repeat (44) @(posedge core_clk);
    check("slow settle", i_host.got.size(), 0);
    emit(dn[1]);
    repeat (56) @(posedge core_clk);
    key_raw[1] <= 1'b0;
    repeat (80) @(posedge core_clk);
    drain("slow settle");
    end_sim();
  end
endmodule
